// file: hdl/parallel_port_control.sv
// Control register logic and bus sequencer of the parallel master port.
//
// The register addresses and the Wishbone register port are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none

// How it works
// - Read kick launches one read, self-clears.
// - Split bit selects separate read/write buffers.
// - Split selection honoured in master mode only.
// - Disabled port makes no external access.
// - Idle stop halts port during idle.
// - Mux 11: low address byte on all data.
// - Mux 10: full address on data pins.
// - Mux 01: low byte data, high on address.
// - Mux 00: address and data separate pins.
// - Write strobe pin gated by its enable.
// - Read strobe pin gated by its enable.
// - Chip selects off in Mux 01, whose upper pins carry address.
// - Unimplemented control bits read as zero.
// - Input buffer select bit drives buffer type.
module parallel_port_control #(
  parameter int ADDR_W = 8
) (
  input  wire logic              core_clk,
  input  wire logic              reset,
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [ADDR_W-1:0] wb_adr_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic [31:0]       wb_dat_i,
  output logic      [31:0]       wb_dat_o,
  output logic                   wb_ack_o,
  input  wire logic              idle_mode,
  input  wire logic              master_mode,
  input  wire logic [15:0]       port_data_pins_i,
  output pport_pkg::pins_t       port_pins,
  output logic                   input_buffer_select
);
  import pport_pkg::*;

  // ****************************************************************
  // Registers
  // ****************************************************************
  logic [31:0] control_r;
  logic [15:0] shared_addr_r;
  logic [15:0] shared_data_r;
  logic [15:0] read_addr_r;
  logic [15:0] read_data_r;
  logic [15:0] write_addr_r;
  logic [15:0] write_data_r;
  logic [15:0] pin_meta_r;
  logic [15:0] pin_sync_r;
  bus_state_t  state_r;
  logic [3:0]  cnt_r;
  logic        op_write_r;
  logic        busy_r;
  logic        wr_pend_r;
  logic [31:0] rd_mux;
  pins_t       pins_nxt;

  logic bus_wr;
  logic bus_rd;
  logic run;
  logic split;
  logic [1:0] mux_sel;
  logic [15:0] cyc_addr;
  logic [15:0] cyc_wdata;
  logic end_read;
  logic [31:0] addr_merged;

  assign bus_wr  = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;
  assign bus_rd  = wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o;
  // The port runs only when enabled and not stopped by idle.
  assign run     = control_r[BIT_ENABLE] && !(control_r[BIT_IDLE_STOP] && idle_mode);
  assign split   = control_r[BIT_SPLIT_BUF] && master_mode;
  assign mux_sel = control_r[BIT_MUX_LO +: 2];
  // Read data is taken only once the settle count has run out.
  assign end_read = (state_r == ST_DONE) && !op_write_r && cnt_r <= 4'h1;

  // Shared or split buffers pick the address and data used by a cycle.
  assign cyc_addr  = split ? (op_write_r ? write_addr_r : read_addr_r) : shared_addr_r;
  assign cyc_wdata = split ? write_data_r : shared_data_r;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] sel);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        res[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return res;
  endfunction

  assign addr_merged = merge({16'h0000, shared_addr_r}, wb_dat_i, wb_sel_i);

  // ****************************************************************
  // Wishbone slave: one wait-free answer, ack one cycle after strobe
  // ****************************************************************
  always_ff @(posedge core_clk) begin
    if (reset) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
    end
  end

  always_comb begin
    rd_mux = 32'h0000_0000;
    case (wb_adr_i[7:0])
      OFS_CONTROL: rd_mux = control_r & CONTROL_WMASK;
      OFS_ADDR:    rd_mux = {16'h0000, shared_addr_r};
      OFS_DATA:    rd_mux = {16'h0000, shared_data_r};
      OFS_RADDR:   rd_mux = {16'h0000, read_addr_r};
      OFS_RDATA:   rd_mux = {16'h0000, read_data_r};
      OFS_WADDR:   rd_mux = {16'h0000, write_addr_r};
      OFS_WDATA:   rd_mux = {16'h0000, write_data_r};
      OFS_STATUS:  rd_mux = {31'h0000_0000, busy_r};
      default:     rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (bus_rd) begin
      wb_dat_o <= rd_mux;
    end
  end

  // ****************************************************************
  // Control register; hardware clear of the kick beats nothing else
  // ****************************************************************
  always_ff @(posedge core_clk) begin
    if (reset) begin
      control_r <= CONTROL_RESET;
    end else begin
      if (bus_wr && wb_adr_i[7:0] == OFS_CONTROL) begin
        // A written zero in the kick bit leaves a pending read alone.
        control_r <= (merge(control_r, wb_dat_i, wb_sel_i) & CONTROL_WMASK)
                     | (control_r & (32'h1 << BIT_READ_KICK) & {32{!end_read}});
        // A read that ends under this write still clears the kick unless it is set anew.
      end else if (end_read) begin
        control_r[BIT_READ_KICK] <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      input_buffer_select <= 1'b0;
    end else begin
      input_buffer_select <= control_r[BIT_TTL_SEL];
    end
  end

  // ****************************************************************
  // Address and data buffers
  // ****************************************************************
  always_ff @(posedge core_clk) begin
    if (reset) begin
      shared_addr_r <= 16'h0000;
      read_addr_r   <= 16'h0000;
      write_addr_r  <= 16'h0000;
      write_data_r  <= 16'h0000;
    end else if (bus_wr) begin
      case (wb_adr_i[7:0])
        OFS_ADDR:  shared_addr_r <= addr_merged[15:0];
        OFS_RADDR: read_addr_r   <= wb_dat_i[15:0];
        OFS_WADDR: write_addr_r  <= wb_dat_i[15:0];
        OFS_WDATA: write_data_r  <= wb_dat_i[15:0];
        default:   ;
      endcase
    end
  end

  // Shared data holds a written value until a read cycle outside split mode replaces it.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      shared_data_r <= 16'h0000;
      read_data_r   <= 16'h0000;
    end else if (end_read) begin
      if (split) begin
        read_data_r <= pin_sync_r;
      end else begin
        shared_data_r <= pin_sync_r;
      end
    end else if (bus_wr && wb_adr_i[7:0] == OFS_DATA) begin
      shared_data_r <= wb_dat_i[15:0];
    end
  end

  // Writing the write-data buffer (shared or split) queues one write cycle.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      wr_pend_r <= 1'b0;
    end else if (bus_wr && ((wb_adr_i[7:0] == OFS_DATA && !split)
                            || (wb_adr_i[7:0] == OFS_WDATA && split))) begin
      wr_pend_r <= 1'b1;
    end else if (state_r == ST_DONE && op_write_r) begin
      wr_pend_r <= 1'b0;
    end
  end

  // Data pins are asynchronous to the core clock.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      pin_meta_r <= 16'h0000;
      pin_sync_r <= 16'h0000;
    end else begin
      pin_meta_r <= port_data_pins_i;
      pin_sync_r <= pin_meta_r;
    end
  end

  // ****************************************************************
  // Bus sequencer: address phase, strobe phase, done
  // ****************************************************************
  always_ff @(posedge core_clk) begin
    if (reset) begin
      state_r    <= ST_IDLE;
      cnt_r      <= 4'h0;
      op_write_r <= 1'b0;
      busy_r     <= 1'b0;
    end else begin
      case (state_r)
        ST_IDLE: begin
          busy_r <= 1'b0;
          // A pending kick or write waits while the port is off or idle-stopped.
          if (run && control_r[BIT_READ_KICK]) begin
            op_write_r <= 1'b0;
            busy_r     <= 1'b1;
            state_r    <= ST_ADDR;
          end else if (run && wr_pend_r) begin
            op_write_r <= 1'b1;
            busy_r     <= 1'b1;
            state_r    <= ST_ADDR;
          end
        end
        ST_ADDR: begin
          cnt_r   <= STROBE_CNT;
          state_r <= ST_STROBE;
        end
        ST_STROBE: begin
          if (cnt_r <= 4'h1) begin
            // The two-flop pin synchroniser lags the pins, so the cycle waits for it.
            cnt_r   <= SETTLE_CNT;
            state_r <= ST_DONE;
          end else begin
            cnt_r <= cnt_r - 4'h1;
          end
        end
        ST_DONE: begin
          if (cnt_r <= 4'h1) begin
            state_r <= ST_IDLE;
          end else begin
            cnt_r <= cnt_r - 4'h1;
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // ****************************************************************
  // Pin drive
  // ****************************************************************
  always_comb begin
    pins_nxt = '0;
    if (run && state_r != ST_IDLE) begin
      case (mux_sel)
        MUX_SEPARATE: begin
          pins_nxt.addr_o = cyc_addr;
          pins_nxt.data_o = cyc_wdata;
        end
        MUX_LOW8: begin
          pins_nxt.addr_o = {cyc_addr[15:8], 8'h00};
          pins_nxt.data_o = (state_r == ST_ADDR) ? {cyc_wdata[15:8], cyc_addr[7:0]} : cyc_wdata;
        end
        MUX_FULL16: begin
          pins_nxt.data_o = (state_r == ST_ADDR) ? cyc_addr : cyc_wdata;
        end
        default: begin
          pins_nxt.data_o = (state_r == ST_ADDR) ? {8'h00, cyc_addr[7:0]} : cyc_wdata;
        end
      endcase
      pins_nxt.data_oe    = (op_write_r || state_r == ST_ADDR) && mux_sel != MUX_SEPARATE
                            ? 16'hFFFF : (op_write_r ? 16'hFFFF : 16'h0000);
      pins_nxt.addr_latch = (state_r == ST_ADDR) && mux_sel != MUX_SEPARATE;
      pins_nxt.rd_strobe  = control_r[BIT_RD_PIN_EN] && !op_write_r
                            && state_r == ST_STROBE;
      pins_nxt.wr_strobe  = control_r[BIT_WR_PIN_EN] && op_write_r
                            && state_r == ST_STROBE;
      // Chip selects are off in low-byte mode, where upper pins carry address; in separate mode cs1 follows inverted address bit 14.
      pins_nxt.cs1 = (mux_sel == MUX_SEPARATE || mux_sel == MUX_FULL16 || mux_sel == MUX_LOW8_ALL)
                     && !pins_nxt.addr_o[14];
      pins_nxt.cs2 = (mux_sel == MUX_FULL16 || mux_sel == MUX_LOW8_ALL);
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      port_pins <= '0;
    end else begin
      port_pins <= pins_nxt;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  sequence s_kick_start;
    run && state_r == ST_IDLE && control_r[BIT_READ_KICK];
  endsequence

  AST_KICK_CLEARS: assert property (@(posedge core_clk) disable iff (reset)
    s_kick_start |-> ##[6:8] !control_r[BIT_READ_KICK])
    else $error("Read kick did not clear after the read cycle.");
  AST_OFF_NO_STROBE: assert property (@(posedge core_clk) disable iff (reset)
    !control_r[BIT_ENABLE] |=> !port_pins.rd_strobe && !port_pins.wr_strobe)
    else $error("Strobe driven while port disabled.");
  AST_IDLE_HOLD: assert property (@(posedge core_clk) disable iff (reset)
    (state_r == ST_IDLE && control_r[BIT_IDLE_STOP] && idle_mode) |=> state_r == ST_IDLE)
    else $error("Cycle started while stopped in idle.");
  AST_RD_GATE: assert property (@(posedge core_clk) disable iff (reset)
    port_pins.rd_strobe |-> $past(control_r[BIT_RD_PIN_EN]))
    else $error("Read strobe active with pin disabled.");
  AST_WR_GATE: assert property (@(posedge core_clk) disable iff (reset)
    port_pins.wr_strobe |-> $past(control_r[BIT_WR_PIN_EN]))
    else $error("Write strobe active with pin disabled.");
  AST_RSVD_ZERO: assert property (@(posedge core_clk) disable iff (reset)
    (control_r & ~CONTROL_WMASK) == 32'h0000_0000)
    else $error("Unimplemented control bits set.");
  AST_FULL_NO_ADDR: assert property (@(posedge core_clk) disable iff (reset)
    $past(mux_sel) == MUX_FULL16 |-> port_pins.addr_o == 16'h0000)
    else $error("Address pins driven in full multiplex mode.");
  AST_LOW8_UPPER: assert property (@(posedge core_clk) disable iff (reset)
    ($past(mux_sel) == MUX_LOW8_ALL && $past(state_r) == ST_ADDR)
      |-> port_pins.data_o[15:8] == 8'h00)
    else $error("Upper address bits driven in low-byte mode.");
  AST_CS_ON_ADDR: assert property (@(posedge core_clk) disable iff (reset)
    $past(mux_sel) == MUX_LOW8 |-> !port_pins.cs1 && !port_pins.cs2)
    else $error("Chip select driven while its pins carry address.");
endmodule // parallel_port_control

`default_nettype wire

// file: hdl/pport_pkg.sv
// Package with register map, field positions and types for the parallel port control block.
package pport_pkg;

  // ****************************************************************
  // Register offsets (byte addresses on the Wishbone side)
  // ****************************************************************
  localparam logic [7:0] OFS_CONTROL   = 8'h00;
  localparam logic [7:0] OFS_ADDR      = 8'h04;
  localparam logic [7:0] OFS_DATA      = 8'h08;
  localparam logic [7:0] OFS_RADDR     = 8'h0C;
  localparam logic [7:0] OFS_RDATA     = 8'h10;
  localparam logic [7:0] OFS_WADDR     = 8'h14;
  localparam logic [7:0] OFS_WDATA     = 8'h18;
  localparam logic [7:0] OFS_STATUS    = 8'h1C;

  // ****************************************************************
  // Control register fields
  // ****************************************************************
  localparam int BIT_READ_KICK   = 23;
  localparam int BIT_SPLIT_BUF   = 17;
  localparam int BIT_ENABLE      = 15;
  localparam int BIT_IDLE_STOP   = 13;
  localparam int BIT_MUX_LO      = 11;
  localparam int BIT_TTL_SEL     = 10;
  localparam int BIT_WR_PIN_EN   = 9;
  localparam int BIT_RD_PIN_EN   = 8;
  localparam logic [31:0] CONTROL_WMASK = 32'h0082_BFFB;
  localparam logic [31:0] CONTROL_RESET = 32'h0000_0000;

  // Address multiplexing schemes.
  localparam logic [1:0] MUX_SEPARATE = 2'b00;
  localparam logic [1:0] MUX_LOW8     = 2'b01;
  localparam logic [1:0] MUX_FULL16   = 2'b10;
  localparam logic [1:0] MUX_LOW8_ALL = 2'b11;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS  = 100;
  localparam int STROBE_NS      = 200;
  localparam int STROBE_CYCLES  = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] STROBE_CNT = STROBE_CYCLES[3:0];
  // Cycles after the strobe so the last strobe-time pin level clears the synchroniser.
  localparam logic [3:0] SETTLE_CNT = 4'h3;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_STROBE,
    ST_DONE
  } bus_state_t;

  typedef struct packed {
    logic [15:0] data_o;
    logic [15:0] data_oe;
    logic [15:0] addr_o;
    logic        rd_strobe;
    logic        wr_strobe;
    logic        cs1;
    logic        cs2;
    logic        addr_latch;
  } pins_t;

endpackage : pport_pkg

// file: verif/pport_peripheral.sv
// Behavioural external peripheral that answers the port's read and write strobes.
`timescale 1ns/1ns
`default_nettype none
module pport_peripheral #(
  parameter logic [15:0] RESP = 16'h3C5A
) (
  input  wire logic             core_clk,
  input  wire logic             reset,
  input  wire pport_pkg::pins_t pins,
  output logic [15:0]           data_o,
  output logic [15:0]           wr_seen
);
  logic [1:0] hold_r;

  // Once its hold time is over the bus shows the inverse of the reply, so a late sample fails.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      hold_r  <= 2'h0;
      data_o  <= ~RESP;
      wr_seen <= 16'h0000;
    end else begin
      if (pins.rd_strobe) begin
        hold_r <= 2'h3;
        data_o <= RESP;
      end else if (hold_r != 2'h0) begin
        hold_r <= hold_r - 2'h1;
      end else begin
        data_o <= ~RESP;
      end
      if (pins.wr_strobe) begin
        wr_seen <= pins.data_o;
      end
    end
  end
endmodule // pport_peripheral
`default_nettype wire

// file: verif/test_parallel_port_control.sv
// Self-checking bench for the parallel port control block.
`timescale 1ns/1ns
`default_nettype none
module test_parallel_port_control;
  import pport_pkg::*;
  localparam logic [15:0] RESP  = 16'h3C5A;
  localparam logic [31:0] Z     = 32'h0000_0000;
  localparam logic [31:0] KICK  = 32'h0080_0000;
  localparam logic [31:0] SPLIT = 32'h0002_0000;
  localparam logic [31:0] EN    = 32'h0000_8000;
  localparam logic [31:0] ISTOP = 32'h0000_2000;
  localparam logic [31:0] WREN  = 32'h0000_0200;
  localparam logic [31:0] RDEN  = 32'h0000_0100;
  logic        core_clk, reset, wb_cyc, wb_stb, wb_we, wb_ack, idle_mode, master_mode, ibs;
  logic [7:0]  wb_adr;
  logic [31:0] wb_wdat, wb_rdat, rd;
  logic [15:0] pdat, wr_seen, lat_data, lat_addr, lat_oe;
  logic [1:0]  lat_cs;
  pins_t       pins;
  int          n_mismatch, cmp_count, rd_cnt, wr_cnt;

  parallel_port_control u_parallel_port_control (
    .core_clk(core_clk), .reset(reset), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
    .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(4'hF), .wb_dat_i(wb_wdat),
    .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack), .idle_mode(idle_mode),
    .master_mode(master_mode), .port_data_pins_i(pdat), .port_pins(pins),
    .input_buffer_select(ibs));
  pport_peripheral #(.RESP(RESP)) u_pport_peripheral (
    .core_clk(core_clk), .reset(reset), .pins(pins), .data_o(pdat), .wr_seen(wr_seen));

  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  // ****************************************************************
  // Pin monitor and shared tasks
  // ****************************************************************
  always @(posedge core_clk) begin
    if (pins.rd_strobe === 1'b1) begin
      rd_cnt++;
      lat_oe = pins.data_oe;
    end
    if (pins.wr_strobe === 1'b1) wr_cnt++;
    // Separate-pin mode has no latch pulse, so the address pins are taken during the strobe.
    if (pins.rd_strobe === 1'b1 || pins.wr_strobe === 1'b1) lat_addr = pins.addr_o;
    if (pins.addr_latch === 1'b1) begin
      lat_data = pins.data_o;
      lat_cs = {pins.cs2, pins.cs1};
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %0t %s: saw %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic conclude();
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic timeout(input string what);
    n_mismatch++;
    $display("BAD %0t %s timed out", $time, what);
    conclude();
  endtask

  // One classic cycle; the request is held until ack is sampled high.
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] d);
    int i;
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= adr;
    wb_wdat <= d;
    i = 0;
    do begin
      @(posedge core_clk);
      i++;
    end while (wb_ack !== 1'b1 && i < 20);
    rd = wb_rdat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    @(posedge core_clk);
    if (i >= 20) timeout("bus answer");
  endtask

  task automatic wait_clear(input logic [7:0] adr, input logic [31:0] mask);
    int i;
    for (i = 0; i < 30; i++) begin
      wb(1'b0, adr, Z);
      if ((rd & mask) === Z) break;
    end
    if (i >= 30) timeout("port cycle");
    repeat (3) @(posedge core_clk);
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic sc_regs();
    wb(1'b0, OFS_CONTROL, Z);
    check(rd, Z, "control reset");
    check({31'h0, ibs}, Z, "buffer select reset");
    wb(1'b1, 8'h40, 32'hFFFF_FFFF);
    wb(1'b0, 8'h40, Z);
    check(rd, Z, "unmapped read");
    wb(1'b1, OFS_CONTROL, 32'hFF7F_FFFF);
    wb(1'b0, OFS_CONTROL, Z);
    check(rd, 32'h0002_BFFB, "unimplemented bits");
    check({31'h0, ibs}, 32'h0000_0001, "ttl select");
    wb(1'b1, OFS_CONTROL, Z);
  endtask

  task automatic sc_enable_idle();
    rd_cnt = 0;
    wb(1'b1, OFS_CONTROL, KICK | RDEN);
    repeat (12) @(posedge core_clk);
    check(rd_cnt, Z, "disabled port strobed");
    wb(1'b1, OFS_CONTROL, EN | KICK | RDEN);
    wait_clear(OFS_CONTROL, KICK);
    check(rd_cnt, STROBE_CYCLES, "one read cycle");
    check({16'h0000, lat_oe}, Z, "data pins driven during read");
    wb(1'b0, OFS_DATA, Z);
    check(rd, {16'h0000, RESP}, "shared read data");
    rd_cnt = 0;
    idle_mode <= 1'b1;
    wb(1'b1, OFS_CONTROL, EN | ISTOP | KICK | RDEN);
    repeat (12) @(posedge core_clk);
    check(rd_cnt, Z, "ran while idle");
    wb(1'b1, OFS_CONTROL, EN | KICK | RDEN);
    wait_clear(OFS_CONTROL, KICK);
    check(rd_cnt, STROBE_CYCLES, "idle without stop");
    idle_mode <= 1'b0;
  endtask

  task automatic sc_strobes();
    rd_cnt = 0;
    wr_cnt = 0;
    wb(1'b1, OFS_CONTROL, EN | KICK);
    wait_clear(OFS_CONTROL, KICK);
    wb(1'b1, OFS_DATA, 32'h0000_1234);
    wait_clear(OFS_STATUS, 32'h0000_0001);
    check(rd_cnt + wr_cnt, Z, "strobe while pin off");
    wb(1'b1, OFS_CONTROL, EN | WREN);
    wb(1'b1, OFS_DATA, 32'h0000_1234);
    wait_clear(OFS_STATUS, 32'h0000_0001);
    check(wr_cnt, STROBE_CYCLES, "write strobe");
    check({16'h0000, wr_seen}, 32'h0000_1234, "written data");
  endtask

  task automatic sc_split();
    master_mode <= 1'b1;
    wb(1'b1, OFS_RADDR, 32'h0000_0042);
    wb(1'b1, OFS_CONTROL, EN | SPLIT | RDEN | WREN | KICK);
    wait_clear(OFS_CONTROL, KICK);
    wb(1'b0, OFS_RDATA, Z);
    check(rd, {16'h0000, RESP}, "split read data");
    check({16'h0000, lat_addr}, 32'h0000_0042, "split read address");
    wb(1'b1, OFS_WDATA, 32'h0000_BEEF);
    wait_clear(OFS_STATUS, 32'h0000_0001);
    check({16'h0000, wr_seen}, 32'h0000_BEEF, "split write data");
    master_mode <= 1'b0;
    wb(1'b1, OFS_DATA, Z);
    wait_clear(OFS_STATUS, 32'h0000_0001);
    wb(1'b1, OFS_CONTROL, EN | SPLIT | RDEN | WREN | KICK);
    wait_clear(OFS_CONTROL, KICK);
    wb(1'b0, OFS_DATA, Z);
    check(rd, {16'h0000, RESP}, "split outside master");
  endtask

  task automatic sc_mux();
    int m;
    for (m = 0; m < 4; m++) begin
      wb(1'b1, OFS_ADDR, 32'h0000_A5C3);
      wb(1'b1, OFS_CONTROL, EN | RDEN | KICK | (32'(m) << BIT_MUX_LO));
      wait_clear(OFS_CONTROL, KICK);
      case (m)
        0: check({16'h0000, lat_addr}, 32'h0000_A5C3, "separate pins");
        1: begin
          check({16'h0000, lat_addr[15:8], lat_data[7:0]}, 32'h0000_A5C3, "low mux");
          check({30'h0, lat_cs}, Z, "chip select on address pins");
        end
        2: check({16'h0000, lat_data}, 32'h0000_A5C3, "full mux");
        default: check({24'h00_0000, lat_data[7:0]}, 32'h0000_00C3, "low on all");
      endcase
    end
  endtask

  initial begin
    n_mismatch = 0;
    cmp_count = 0;
    rd_cnt = 0;
    wr_cnt = 0;
    reset = 1'b1;
    wb_cyc = 1'b0;
    wb_stb = 1'b0;
    wb_we = 1'b0;
    wb_adr = 8'h00;
    wb_wdat = Z;
    idle_mode = 1'b0;
    master_mode = 1'b0;
    repeat (4) @(posedge core_clk);
    reset <= 1'b0;
    @(posedge core_clk);
    sc_regs();
    sc_enable_idle();
    sc_strobes();
    sc_split();
    sc_mux();
    conclude();
  end
endmodule // test_parallel_port_control
`default_nettype wire
